// ===== core/cmc_clock_mode_ctrl.sv
// What this block does
// - Two internal sources: fast RC at 4, 8 or 12 MHz, slow RC 32 kHz.
// - Select codes 000 to 110 divide fast clock by 1..64; 111 picks sub clock.
// - Fast running mode clocks the core from the fast RC, divided 1 to 64.
// - Slow running mode clocks the core from the sub clock of the slow RC.
// - After switching to sub clock, fast RC stops or runs per enable bit only.
// - Six modes: fast and slow running, sleep and three idle with CPU stopped.
// - Halt with both keep bits low enters sleep and stops the CPU.
// - Sleep stops sub clock; slow RC runs only while watchdog is enabled.
// - Oscillators also feed the watchdog and the time base.
// - Both a fast and a slow oscillator always exist; none may be deselected.
// - Keep bits at halt pick sleep, idle_sub_only_mode, idle_both_clocks_mode or idle_fast_only_mode.
// - Frequency field: 00 4 MHz, 01 8 MHz, 10 12 MHz, 11 4 MHz.
// - Setting the fast enable clears the stable flag, set again once stable.
`timescale 1ns/1ps
`default_nettype none

module cmc_clock_mode_ctrl
  import cmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic haltInsn,
  input wire logic wakeEvent,
  input wire logic watchdogEnable,
  output cmc_clk_out_t clkOut,
  output cmc_mode_t modeOut
);

  // ==========================================================
  // Decoding functions
  // ==========================================================
  function automatic logic [15:0] fastStep(input logic [1:0] sel);
    case (sel)
      2'h1: fastStep = FAST_STEP_8;
      2'h2: fastStep = FAST_STEP_12;
      default: fastStep = FAST_STEP_4;
    endcase
  endfunction

  function automatic logic [5:0] divMask(input logic [2:0] sel);
    case (sel)
      3'h0: divMask = 6'h00;
      3'h1: divMask = 6'h01;
      3'h2: divMask = 6'h03;
      3'h3: divMask = 6'h07;
      3'h4: divMask = 6'h0f;
      3'h5: divMask = 6'h1f;
      default: divMask = 6'h3f;
    endcase
  endfunction

  function automatic cmc_mode_t haltTarget(input logic fastKeep, input logic slowKeep);
    case ({fastKeep, slowKeep})
      2'b01: haltTarget = MODE_IDLE_SUB_ONLY_MODE;
      2'b11: haltTarget = MODE_IDLE_BOTH_CLOCKS_MODE;
      2'b10: haltTarget = MODE_IDLE_FAST_ONLY_MODE;
      default: haltTarget = MODE_SLEEP;
    endcase
  endfunction

  function automatic cmc_mode_t runMode(input logic [2:0] sel);
    runMode = (sel == CLK_SEL_SUB) ? MODE_SLOW : MODE_FAST;
  endfunction

  // ==========================================================
  // Registers
  // ==========================================================
  logic [2:0] coreClockSelect_r;
  logic fastOscKeepInHalt_r;
  logic slowOscKeepInHalt_r;
  logic [1:0] fastOscFreqSelect_r;
  logic fastOscEnable_r;
  logic fastOscStableFlag_r;
  logic [15:0] stableCnt_r;
  logic [5:0] divCnt_r;
  cmc_mode_t mode_r;
  cmc_mode_t mode_nxt;

  logic wbReq;
  logic wbWrite;
  logic [31:0] rdData;
  logic fastOscEnableRise;

  logic fastOscOn;
  logic slowOscOn;
  logic subOn;
  logic coreOn;
  logic cpuRun;
  logic fastTick;
  logic slowTick;
  logic coreTick;
  logic selDivided;

  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWrite = wbReq && wb_we_i && wb_sel_i[0];
  assign selDivided = coreClockSelect_r != CLK_SEL_SUB;

  // ==========================================================
  // Wishbone slave
  // ==========================================================
  always_comb begin
    rdData = 32'h00000000;
    case (wb_adr_i)
      SYS_CLOCK_CONTROL_REG_ADDR: begin
        rdData[CLK_SEL_LSB +: 3] = coreClockSelect_r;
        rdData[FAST_KEEP_BIT] = fastOscKeepInHalt_r;
        rdData[SLOW_KEEP_BIT] = slowOscKeepInHalt_r;
      end
      FAST_OSC_CONTROL_REG_ADDR: begin
        rdData[FREQ_SEL_LSB +: 2] = fastOscFreqSelect_r;
        rdData[STABLE_BIT] = fastOscStableFlag_r;
        rdData[FAST_EN_BIT] = fastOscEnable_r;
      end
      MODE_STATUS_REG_ADDR: begin
        rdData[5:0] = mode_r;
      end
      default: begin
        rdData = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wbReq;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (wbReq && !wb_we_i) begin
      wb_dat_o <= rdData;
    end
  end

  // ==========================================================
  // System clock control register
  // ==========================================================
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      coreClockSelect_r <= CLK_SEL_RST;
      fastOscKeepInHalt_r <= 1'b0;
      slowOscKeepInHalt_r <= 1'b0;
    end else if (wbWrite && wb_adr_i == SYS_CLOCK_CONTROL_REG_ADDR) begin
      coreClockSelect_r <= wb_dat_i[CLK_SEL_LSB +: 3];
      fastOscKeepInHalt_r <= wb_dat_i[FAST_KEEP_BIT];
      slowOscKeepInHalt_r <= wb_dat_i[SLOW_KEEP_BIT];
    end
  end

  // ==========================================================
  // Fast oscillator control register
  // ==========================================================
  assign fastOscEnableRise = wbWrite && wb_adr_i == FAST_OSC_CONTROL_REG_ADDR
    && wb_dat_i[FAST_EN_BIT] && !fastOscEnable_r;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fastOscFreqSelect_r <= FREQ_SEL_RST;
      fastOscEnable_r <= FAST_EN_RST;
    end else if (wbWrite && wb_adr_i == FAST_OSC_CONTROL_REG_ADDR) begin
      fastOscFreqSelect_r <= wb_dat_i[FREQ_SEL_LSB +: 2];
      fastOscEnable_r <= wb_dat_i[FAST_EN_BIT];
    end
  end

  // ==========================================================
  // Stable flag
  // ==========================================================
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stableCnt_r <= 16'h0000;
    end else if (!fastOscOn || fastOscEnableRise) begin
      stableCnt_r <= 16'h0000;
    end else if (stableCnt_r != 16'(FAST_STABLE_CYC)) begin
      stableCnt_r <= stableCnt_r + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fastOscStableFlag_r <= 1'b0;
    end else if (!fastOscOn || fastOscEnableRise) begin
      fastOscStableFlag_r <= 1'b0;
    end else if (stableCnt_r == 16'(FAST_STABLE_CYC)) begin
      fastOscStableFlag_r <= 1'b1;
    end
  end

  // ==========================================================
  // Operating mode state machine
  // ==========================================================
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      MODE_FAST, MODE_SLOW: begin
        if (haltInsn) begin
          mode_nxt = haltTarget(fastOscKeepInHalt_r, slowOscKeepInHalt_r);
        end else begin
          mode_nxt = runMode(coreClockSelect_r);
        end
      end
      MODE_SLEEP, MODE_IDLE_SUB_ONLY_MODE, MODE_IDLE_BOTH_CLOCKS_MODE, MODE_IDLE_FAST_ONLY_MODE: begin
        if (wakeEvent) begin
          mode_nxt = runMode(coreClockSelect_r);
        end
      end
      default: begin
        mode_nxt = MODE_FAST;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= MODE_FAST;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ==========================================================
  // Oscillator and clock gating per mode
  // ==========================================================
  always_comb begin
    fastOscOn = 1'b0;
    slowOscOn = 1'b1;
    subOn = 1'b1;
    coreOn = 1'b0;
    cpuRun = 1'b0;
    case (mode_r)
      MODE_FAST: begin
        fastOscOn = 1'b1;
        coreOn = 1'b1;
        cpuRun = 1'b1;
      end
      MODE_SLOW: begin
        fastOscOn = fastOscEnable_r;
        coreOn = 1'b1;
        cpuRun = 1'b1;
      end
      MODE_IDLE_SUB_ONLY_MODE: begin
        coreOn = !selDivided;
      end
      MODE_IDLE_BOTH_CLOCKS_MODE: begin
        fastOscOn = 1'b1;
        coreOn = 1'b1;
      end
      MODE_IDLE_FAST_ONLY_MODE: begin
        fastOscOn = 1'b1;
        subOn = 1'b0;
        coreOn = selDivided;
      end
      MODE_SLEEP: begin
        subOn = 1'b0;
        slowOscOn = watchdogEnable;
      end
      default: begin
        fastOscOn = 1'b1;
        coreOn = 1'b1;
        cpuRun = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Oscillators
  // ==========================================================
  cmc_rc_tick u_fast_rc_oscillator (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .oscOn(fastOscOn),
    .step(fastStep(fastOscFreqSelect_r)),
    .modulus(FAST_MOD),
    .tick(fastTick)
  );

  cmc_rc_tick u_slow_rc_oscillator (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .oscOn(slowOscOn),
    .step(SLOW_STEP),
    .modulus(SLOW_MOD),
    .tick(slowTick)
  );

  // ==========================================================
  // Core clock divider
  // ==========================================================
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_r <= 6'h00;
    end else if (!fastOscOn) begin
      divCnt_r <= 6'h00;
    end else if (fastTick) begin
      divCnt_r <= divCnt_r + 6'h01;
    end
  end

  always_comb begin
    if (selDivided) begin
      coreTick = fastTick && ((divCnt_r & divMask(coreClockSelect_r))
        == divMask(coreClockSelect_r));
    end else begin
      coreTick = slowTick && subOn;
    end
  end

  // ==========================================================
  // Registered outputs
  // ==========================================================
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clkOut <= '0;
    end else begin
      clkOut.cpuRun <= cpuRun;
      clkOut.coreClockTick <= coreTick && coreOn;
      clkOut.fastClockTick <= fastTick;
      clkOut.subClockTick <= slowTick && subOn;
      clkOut.slowOscTick <= slowTick;
      clkOut.fastOscOn <= fastOscOn;
      clkOut.slowOscOn <= slowOscOn;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      modeOut <= MODE_FAST;
    end else begin
      modeOut <= mode_r;
    end
  end

endmodule

`default_nettype wire

// ===== core/cmc_rc_tick.sv
`timescale 1ns/1ps
`default_nettype none

module cmc_rc_tick
  import cmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic oscOn,
  input wire logic [15:0] step,
  input wire logic [15:0] modulus,
  output logic tick
);

  // ==========================================================
  // Phase accumulator at the nominal rate
  // ==========================================================
  logic [16:0] accSum;
  logic [15:0] acc_r;

  assign accSum = {1'b0, acc_r} + {1'b0, step};

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r <= 16'h0000;
    end else if (!oscOn) begin
      acc_r <= 16'h0000;
    end else if (accSum >= {1'b0, modulus}) begin
      acc_r <= 16'(accSum - {1'b0, modulus});
    end else begin
      acc_r <= accSum[15:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick <= 1'b0;
    end else begin
      tick <= oscOn && (accSum >= {1'b0, modulus});
    end
  end

endmodule

`default_nettype wire

// ===== inc/cmc_pkg.sv
package cmc_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int SYS_CLK_KHZ = 40000;
  localparam int SYS_CLK_MHZ = 40;
  localparam int FAST_STABLE_US = 16;
  localparam int FAST_STABLE_CYC = FAST_STABLE_US * SYS_CLK_MHZ;
  localparam int SLOW_OSC_KHZ = 32;
  localparam logic [15:0] SLOW_STEP = 16'(SLOW_OSC_KHZ);
  localparam logic [15:0] SLOW_MOD = 16'(SYS_CLK_KHZ);
  localparam logic [15:0] FAST_MOD = 16'(SYS_CLK_MHZ);
  localparam logic [15:0] FAST_STEP_4 = 16'h0004;
  localparam logic [15:0] FAST_STEP_8 = 16'h0008;
  localparam logic [15:0] FAST_STEP_12 = 16'h000c;

  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [7:0] SYS_CLOCK_CONTROL_REG_ADDR = 8'h00;
  localparam logic [7:0] FAST_OSC_CONTROL_REG_ADDR = 8'h04;
  localparam logic [7:0] MODE_STATUS_REG_ADDR = 8'h08;
  localparam int CLK_SEL_LSB = 5;
  localparam int FAST_KEEP_BIT = 1;
  localparam int SLOW_KEEP_BIT = 0;
  localparam int FREQ_SEL_LSB = 2;
  localparam int STABLE_BIT = 1;
  localparam int FAST_EN_BIT = 0;
  localparam logic [2:0] CLK_SEL_RST = 3'h0;
  localparam logic [2:0] CLK_SEL_SUB = 3'h7;
  localparam logic [1:0] FREQ_SEL_RST = 2'h0;
  localparam logic FAST_EN_RST = 1'b1;

  // ==========================================================
  // Operating modes
  // ==========================================================
  typedef enum logic [5:0] {
    MODE_FAST  = 6'h01,
    MODE_SLOW  = 6'h02,
    MODE_SLEEP = 6'h04,
    MODE_IDLE_SUB_ONLY_MODE = 6'h08,
    MODE_IDLE_BOTH_CLOCKS_MODE = 6'h10,
    MODE_IDLE_FAST_ONLY_MODE = 6'h20
  } cmc_mode_t;

  // ==========================================================
  // Clock enables to the consumers
  // ==========================================================
  typedef struct packed {
    logic cpuRun;
    logic coreClockTick;
    logic fastClockTick;
    logic subClockTick;
    logic slowOscTick;
    logic fastOscOn;
    logic slowOscOn;
  } cmc_clk_out_t;

endpackage

// ===== test/cmc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Core and peripheral side
module cmc_core_model
  import cmc_pkg::*;
(
  input wire logic sys_clk,
  input wire cmc_clk_out_t clkOut,
  output logic haltInsn,
  output logic wakeEvent,
  output int coreCount,
  output int fastCount
);
  initial begin
    haltInsn = 1'b0;
    wakeEvent = 1'b0;
    coreCount = 0;
    fastCount = 0;
  end
  always @(posedge sys_clk) begin
    coreCount <= coreCount + int'(clkOut.coreClockTick === 1'b1);
    fastCount <= fastCount + int'(clkOut.fastClockTick === 1'b1);
  end
  // Pulse halt or wake high for one sys_clk cycle
  task automatic pulse(input logic isWake);
    @(posedge sys_clk);
    if (isWake)
      wakeEvent <= 1'b1;
    else
      haltInsn <= 1'b1;
    @(posedge sys_clk);
    wakeEvent <= 1'b0;
    haltInsn <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== test/cmc_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Port checks
module cmc_ctrl_asserts
  import cmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic haltInsn,
  input wire logic wakeEvent,
  input wire logic watchdogEnable,
  input wire cmc_clk_out_t clkOut,
  input wire cmc_mode_t modeOut
);
  logic up_r;
  logic run;
  assign run = modeOut == MODE_FAST || modeOut == MODE_SLOW;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)
      up_r <= 1'b0;
    else
      up_r <= 1'b1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle");
  a_halt_stops: assert property (up_r && run && haltInsn |-> ##2 !run && !clkOut.cpuRun)
    else $error("halt did not stop cpu");
  a_wake_runs: assert property (up_r && !run && wakeEvent |-> ##2 run && clkOut.cpuRun)
    else $error("wake did not run cpu");
  a_cpu_gate: assert property (up_r |-> clkOut.cpuRun == run)
    else $error("cpu gate off mode");
  a_sleep_quiet: assert property (up_r && modeOut == MODE_SLEEP |->
    !(clkOut.subClockTick || clkOut.fastOscOn || clkOut.coreClockTick))
    else $error("clock alive in sleep");
  a_sleep_wdog: assert property ((modeOut == MODE_SLEEP && $stable(watchdogEnable)) [*3]
    |-> clkOut.slowOscOn == watchdogEnable)
    else $error("slow osc off watchdog");
  a_idle_fast: assert property (up_r && !run && modeOut != MODE_SLEEP
    |-> clkOut.fastOscOn == (modeOut == MODE_IDLE_BOTH_CLOCKS_MODE || modeOut == MODE_IDLE_FAST_ONLY_MODE))
    else $error("fast osc wrong in idle");
  a_slow_live: assert property (up_r && modeOut != MODE_SLEEP |-> clkOut.slowOscOn)
    else $error("slow osc stopped");
  a_fast_live: assert property (up_r && modeOut == MODE_FAST |-> clkOut.fastOscOn)
    else $error("fast osc off in fast mode");
  a_sub_space: assert property (clkOut.subClockTick |=> !clkOut.subClockTick [*8])
    else $error("sub ticks too close");
  a_idle_fast_only_mode_sub: assert property (modeOut == MODE_IDLE_FAST_ONLY_MODE |-> !clkOut.subClockTick)
    else $error("sub tick in idle_fast_only_mode");
  a_wdog_tick: assert property (!clkOut.slowOscOn |=> !clkOut.slowOscTick)
    else $error("slow tick with osc off");
  c_sleep: cover property (modeOut == MODE_SLEEP && watchdogEnable);
  c_idle_both_clocks_mode: cover property (modeOut == MODE_IDLE_BOTH_CLOCKS_MODE && clkOut.coreClockTick);
  c_slow: cover property (modeOut == MODE_SLOW && clkOut.subClockTick);
endmodule
bind cmc_clock_mode_ctrl cmc_ctrl_asserts cmc_ctrl_asserts_inst (
  .sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .haltInsn(haltInsn), .wakeEvent(wakeEvent),
  .watchdogEnable(watchdogEnable), .clkOut(clkOut), .modeOut(modeOut));
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cmc_pkg::*;
;
  logic sys_clk, reset_n, wbCyc, wbStb, wbWe, wbAck, haltInsn, wakeEvent, watchdogEnable;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI, wbDatO, rd;
  cmc_clk_out_t clkOut;
  cmc_mode_t modeOut;
  int coreCount, fastCount, c0, f0, miscompares, checked;
  int rowSel[11] = '{0, 1, 2, 3, 4, 5, 6, 0, 0, 0, 7};
  int rowFreq[11] = '{0, 0, 0, 0, 0, 0, 0, 1, 2, 3, 0};
  int rowCore[11] = '{320, 160, 80, 40, 20, 10, 5, 640, 960, 320, 3};
  int rowFast[11] = '{320, 320, 320, 320, 320, 320, 320, 640, 960, 320, 320};
  int keep[4] = '{0, 1, 3, 2};
  int idleCore[4] = '{0, 0, 10, 10};
  cmc_mode_t haltMode[4] = '{MODE_SLEEP, MODE_IDLE_SUB_ONLY_MODE, MODE_IDLE_BOTH_CLOCKS_MODE, MODE_IDLE_FAST_ONLY_MODE};
  cmc_clock_mode_ctrl cmc_clock_mode_ctrl_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .haltInsn(haltInsn),
    .wakeEvent(wakeEvent), .watchdogEnable(watchdogEnable), .clkOut(clkOut),
    .modeOut(modeOut));
  cmc_core_model cmc_core_model_inst (.sys_clk(sys_clk), .clkOut(clkOut),
    .haltInsn(haltInsn), .wakeEvent(wakeEvent), .coreCount(coreCount),
    .fastCount(fastCount));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_near(input string name, input int exp, input int got);
    checked++;
    if (got > exp + 1 || got < exp - 1) begin
      miscompares++;
      $display("unexpected %s: expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    rd = wbDatO;
    check_val("ack wait", 32'd2, n);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    {reset_n, wbCyc, wbStb, wbWe, watchdogEnable} = '0;
    {wbAdr, wbDatI} = '0;
    wbSel = 4'h1;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    wb(1'b0, SYS_CLOCK_CONTROL_REG_ADDR, 32'h0);
    check_val("clock control", 32'h0, rd);
    repeat (FAST_STABLE_CYC + 8) @(posedge sys_clk);
    wb(1'b0, FAST_OSC_CONTROL_REG_ADDR, 32'h0);
    check_val("fast control", 32'h3, rd);
    wb(1'b0, MODE_STATUS_REG_ADDR, 32'h0);
    check_val("mode status", 32'h1, rd);
    wb(1'b1, 8'h0c, 32'hff);
    wb(1'b0, 8'h0c, 32'h0);
    check_val("unmapped", 32'h0, rd);
    wbSel <= 4'h0;
    wb(1'b1, SYS_CLOCK_CONTROL_REG_ADDR, 32'he3);
    wbSel <= 4'h1;
    wb(1'b0, SYS_CLOCK_CONTROL_REG_ADDR, 32'h0);
    check_val("masked write", 32'h0, rd);
    for (int i = 0; i < 11; i++) begin
      wb(1'b1, FAST_OSC_CONTROL_REG_ADDR, {28'h0, rowFreq[i][1:0], 2'h1});
      wb(1'b1, SYS_CLOCK_CONTROL_REG_ADDR, {24'h0, rowSel[i][2:0], 5'h0});
      repeat (16) @(posedge sys_clk);
      c0 = coreCount;
      f0 = fastCount;
      repeat (3200) @(posedge sys_clk);
      check_near("core ticks", rowCore[i], coreCount - c0);
      check_near("fast ticks", rowFast[i], fastCount - f0);
      check_val("mode", (rowSel[i] == 7) ? MODE_SLOW : MODE_FAST, modeOut);
    end
    wb(1'b1, FAST_OSC_CONTROL_REG_ADDR, 32'h0);
    repeat (8) @(posedge sys_clk);
    check_val("fast osc off", 32'h0, clkOut.fastOscOn);
    wb(1'b1, FAST_OSC_CONTROL_REG_ADDR, 32'h1);
    wb(1'b0, FAST_OSC_CONTROL_REG_ADDR, 32'h0);
    check_val("stable cleared", 32'h1, rd);
    check_val("fast osc on", 32'h1, clkOut.fastOscOn);
    repeat (FAST_STABLE_CYC + 8) @(posedge sys_clk);
    wb(1'b0, FAST_OSC_CONTROL_REG_ADDR, 32'h0);
    check_val("stable set", 32'h3, rd);
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, SYS_CLOCK_CONTROL_REG_ADDR, {30'h0, keep[k][1:0]});
      cmc_core_model_inst.pulse(1'b0);
      repeat (4) @(posedge sys_clk);
      check_val("halt mode", haltMode[k], modeOut);
      check_val("cpu run", 32'h0, clkOut.cpuRun);
      c0 = coreCount;
      repeat (100) @(posedge sys_clk);
      check_near("idle core ticks", idleCore[k], coreCount - c0);
      if (k == 0) begin
        watchdogEnable <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check_val("watchdog osc", 32'h1, clkOut.slowOscOn);
        watchdogEnable <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check_val("watchdog osc", 32'h0, clkOut.slowOscOn);
      end
      cmc_core_model_inst.pulse(1'b1);
      repeat (4) @(posedge sys_clk);
      check_val("woken mode", MODE_FAST, modeOut);
    end
    repeat (FAST_STABLE_CYC + 8) @(posedge sys_clk);
    wb(1'b1, FAST_OSC_CONTROL_REG_ADDR, 32'h0);
    wb(1'b0, FAST_OSC_CONTROL_REG_ADDR, 32'h0);
    check_val("stable kept", 32'h2, rd);
    wb(1'b1, FAST_OSC_CONTROL_REG_ADDR, 32'h1);
    wb(1'b0, FAST_OSC_CONTROL_REG_ADDR, 32'h0);
    check_val("stable on rise", 32'h1, rd);
    reset_n <= 1'b0;
    @(posedge sys_clk);
    check_val("reset mode", MODE_FAST, modeOut);
    check_val("reset clocks", 32'h0, clkOut);
    reset_n <= 1'b1;
    wb(1'b0, SYS_CLOCK_CONTROL_REG_ADDR, 32'h0);
    check_val("reset clock control", 32'h0, rd);
    tally_and_finish;
  end
endmodule
`default_nettype wire
